// ===== aicp_cmd_parser.sv
// Top of the ASCII command interpreter: parse, defer, commit, reply
`timescale 1ns/1ps
`default_nettype none
`include "aicp_params.svh"
module aicp_cmd_parser (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Command bytes from the host
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxEoi,
  output logic rxReady,
  // Reply bytes to the host
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  // Applied settings
  output logic outpState,
  output logic trigExt,
  // Status flags
  output logic conflictErr,
  output logic cmdErr
);
  aicp_tok_if tok ();
  aicp_lexer u_lexer (
    .clk_sys(clk_sys), .resetn(resetn), .rxData(rxData),
    .rxValid(rxValid), .rxEoi(rxEoi), .rxReady(rxReady), .tok(tok)
  );
  aicp_pkg::aicp_state_e state;
  aicp_pkg::aicp_sub_e cmdSub, nxSub;
  aicp_pkg::aicp_word_e leaf, w, finLeaf;
  aicp_pkg::aicp_seg_e seg;
  logic atStart, common, query, inParam, shOutp, shTrig, resume;
  logic [2:0] qMask, pend, nxMask;
  logic [5:0] idx, segLen, byteSel;
  logic endCmd, isEol, finQuery, pOn, pOff, pExt, pInt;
  logic doRst, doCls, qOpc, qLrn, qErr, setOutp, setTrig;
  logic known, emptyCmd, badCmd, nxOutp, nxTrig, conflict;
  logic load, segDone, errRead;
  logic [`AICP_MSG_BITS-1:0] lrnMsg, segMsg, shifted;
  logic [7:0] segChar;
  function automatic aicp_pkg::aicp_seg_e firstSeg(input logic [2:0] m);
    firstSeg = m[0] ? aicp_pkg::SEG_LRN :
               m[1] ? aicp_pkg::SEG_ERR : aicp_pkg::SEG_OPC;
  endfunction
  assign tok.resume = resume;

  // ==========================================================
  // Command decode
  assign w = tok.tokWord;
  assign endCmd = tok.tokValid &&
                  (tok.tokDelim == `AICP_CH_SEMI || tok.tokEol);
  assign isEol = endCmd && tok.tokEol;
  assign finLeaf = (!inParam && w != aicp_pkg::W_NONE) ? w : leaf;
  assign finQuery = query || tok.tokDelim == `AICP_CH_QUERY;
  assign pOn = inParam && (w == aicp_pkg::W_ON || w == aicp_pkg::W_ONE);
  assign pOff = inParam && (w == aicp_pkg::W_OFF || w == aicp_pkg::W_ZERO);
  assign pExt = inParam && w == aicp_pkg::W_EXT;
  assign pInt = inParam && w == aicp_pkg::W_INT;
  assign nxSub = (w == aicp_pkg::W_NONE && atStart) ? aicp_pkg::SUB_NONE :
                 cmdSub != aicp_pkg::SUB_NONE ? aicp_pkg::SUB_BAD :
                 w == aicp_pkg::W_OUTP ? aicp_pkg::SUB_OUTP :
                 w == aicp_pkg::W_TRIG ? aicp_pkg::SUB_TRIG :
                 w == aicp_pkg::W_SYST ? aicp_pkg::SUB_SYST :
                 aicp_pkg::SUB_BAD;
  assign doRst = endCmd && common && finLeaf == aicp_pkg::W_RST && !finQuery;
  assign doCls = endCmd && common && finLeaf == aicp_pkg::W_CLS && !finQuery;
  assign qOpc = endCmd && common && finLeaf == aicp_pkg::W_OPC && finQuery;
  assign qLrn = endCmd && common && finLeaf == aicp_pkg::W_LRN && finQuery;
  assign qErr = endCmd && !common && cmdSub == aicp_pkg::SUB_SYST &&
                finLeaf == aicp_pkg::W_ERR && finQuery;
  assign setOutp = endCmd && !common && cmdSub == aicp_pkg::SUB_OUTP &&
                   finLeaf == aicp_pkg::W_STAT && !finQuery && (pOn || pOff);
  assign setTrig = endCmd && !common && cmdSub == aicp_pkg::SUB_TRIG &&
                   finLeaf == aicp_pkg::W_SOUR && !finQuery && (pExt || pInt);
  assign known = doRst || doCls || qOpc || qLrn || qErr || setOutp ||
                 setTrig;
  assign emptyCmd = !common && !inParam && finLeaf == aicp_pkg::W_NONE;
  assign badCmd = endCmd && !known && !emptyCmd;
  assign nxOutp = doRst ? `AICP_RST_OUTP : setOutp ? pOn : shOutp;
  assign nxTrig = doRst ? `AICP_RST_TRIG : setTrig ? pExt : shTrig;
  // output on with external trigger is illegal
  assign conflict = isEol && nxOutp && nxTrig;
  assign nxMask = qMask | {qOpc, qErr, qLrn};

  // ==========================================================
  // Header walk
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmdSub <= aicp_pkg::SUB_NONE;
      leaf <= aicp_pkg::W_NONE;
      atStart <= 1'b1;
      common <= 1'b0;
      query <= 1'b0;
      inParam <= 1'b0;
    end else if (endCmd) begin
      // semicolon keeps level, new line starts at root
      cmdSub <= (isEol || cmdSub == aicp_pkg::SUB_BAD) ?
                aicp_pkg::SUB_NONE : cmdSub;
      leaf <= aicp_pkg::W_NONE;
      atStart <= 1'b1;
      common <= 1'b0;
      query <= 1'b0;
      inParam <= 1'b0;
    end else if (tok.tokValid) begin
      // Bare spaces before a header leave the command at its start
      atStart <= atStart && w == aicp_pkg::W_NONE &&
                 tok.tokDelim == `AICP_CH_SP;
      case (tok.tokDelim)
        `AICP_CH_COLON: cmdSub <= nxSub;
        `AICP_CH_STAR: common <= 1'b1;
        `AICP_CH_QUERY: begin
          query <= 1'b1;
          leaf <= finLeaf;
        end
        `AICP_CH_SP: begin
          if (w != aicp_pkg::W_NONE && !inParam) begin
            leaf <= w;
            inParam <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Settings and status
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shOutp <= `AICP_RST_OUTP;
      shTrig <= `AICP_RST_TRIG;
      outpState <= `AICP_RST_OUTP;
      trigExt <= `AICP_RST_TRIG;
      conflictErr <= 1'b0;
      cmdErr <= 1'b0;
    end else begin
      // settings wait in shadow until line end; *RST applies at once
      shOutp <= conflict ? `AICP_SUB_OUTP : nxOutp;
      shTrig <= nxTrig;
      if (isEol || doRst) begin
        outpState <= conflict ? `AICP_SUB_OUTP : nxOutp;
        trigExt <= nxTrig;
      end
      // clear, but a new error wins
      conflictErr <= conflict || (conflictErr && !(doCls || errRead));
      cmdErr <= badCmd || (cmdErr && !doCls);
    end
  end

  // ==========================================================
  // Reply text
  // learn text with semicolon between settings
  assign lrnMsg = {136'h0, "OUTP:STAT ", `AICP_CH_ZERO + {7'h00, outpState},
                   ";TRIG:SOUR ", trigExt ? "EXT" : "INT"};
  assign segMsg = seg == aicp_pkg::SEG_LRN ? lrnMsg :
                  seg == aicp_pkg::SEG_OPC ?
                  `AICP_MSG_BITS'(`AICP_CH_ONE) :
                  conflictErr ? `AICP_MSG_BITS'(`AICP_ERR_TEXT) :
                  `AICP_MSG_BITS'(`AICP_NOERR_TEXT);
  assign segLen = seg == aicp_pkg::SEG_LRN ? `AICP_LRN_LEN :
                  seg == aicp_pkg::SEG_OPC ? `AICP_OPC_LEN :
                  conflictErr ? `AICP_ERR_LEN : `AICP_NOERR_LEN;
  assign byteSel = 6'(segLen - idx - 6'h01);
  assign shifted = segMsg >> {byteSel, 3'b000};
  assign segChar = shifted[7:0];
  assign load = state == aicp_pkg::ST_EMIT && (!txValid || txReady);
  assign segDone = idx == segLen;
  assign errRead = load && segDone && seg == aicp_pkg::SEG_ERR;

  // ==========================================================
  // Reply sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= aicp_pkg::ST_PARSE;
      seg <= aicp_pkg::SEG_LRN;
      pend <= 3'b000;
      qMask <= 3'b000;
      idx <= 6'h00;
      txData <= 8'h00;
      txValid <= 1'b0;
      resume <= 1'b0;
    end else begin
      resume <= 1'b0;
      txValid <= txValid && !txReady;
      unique case (state)
        aicp_pkg::ST_PARSE: begin
          if (isEol) begin
            qMask <= 3'b000;
            // work is done by line end, so the answer is ready
            if (nxMask != 3'b000) begin
              state <= aicp_pkg::ST_EMIT;
              seg <= firstSeg(nxMask);
              pend <= nxMask & 3'(nxMask - 3'b001);
              idx <= 6'h00;
            end else begin
              resume <= 1'b1;
            end
          end else if (endCmd) begin
            qMask <= nxMask;
          end
        end
        aicp_pkg::ST_EMIT: begin
          if (load) begin
            txValid <= 1'b1;
            if (!segDone) begin
              txData <= segChar;
              idx <= 6'(idx + 6'h01);
            end else if (pend != 3'b000) begin
              txData <= `AICP_CH_SEMI;
              seg <= firstSeg(pend);
              pend <= pend & 3'(pend - 3'b001);
              idx <= 6'h00;
            end else begin
              txData <= `AICP_CH_LF;
              state <= aicp_pkg::ST_PARSE;
              resume <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence sMidLine;
    tok.tokValid && !tok.tokEol && !doRst;
  endsequence
  sequence sLastLoad;
    load && segDone && pend == 3'b000;
  endsequence
  sequence sLfOut;
    txValid && txData == `AICP_CH_LF && state == aicp_pkg::ST_PARSE;
  endsequence
  AST_RST: assert property (
    doRst |=> outpState == `AICP_RST_OUTP && trigExt == `AICP_RST_TRIG)
    else $error("reset did not restore settings");
  AST_CLS: assert property (
    doCls && !conflict |=> !conflictErr && !cmdErr)
    else $error("clear left a status flag");
  AST_OPC_ONE: assert property (
    load && seg == aicp_pkg::SEG_OPC && !segDone |=>
      txValid && txData == `AICP_CH_ONE)
    else $error("completion reply not 1");
  AST_LRN_SEP: assert property (
    load && seg == aicp_pkg::SEG_LRN && idx == `AICP_LRN_SEMI_POS |=>
      txData == `AICP_CH_SEMI)
    else $error("learn settings not separated");
  AST_ASCII: assert property (
    txValid |-> !txData[7])
    else $error("reply byte outside ASCII");
  AST_DEFER: assert property (
    sMidLine |=> $stable(outpState) && $stable(trigExt))
    else $error("setting applied before line end");
  AST_CONFLICT: assert property (
    conflict |=> conflictErr && outpState == `AICP_SUB_OUTP && trigExt)
    else $error("conflict not flagged or not substituted");
  AST_ERR_MSG: assert property (
    load && seg == aicp_pkg::SEG_ERR && conflictErr && idx == 6'h00 |=>
      txData == `AICP_CH_MINUS ##1 !txValid || txData != `AICP_CH_LF)
    else $error("conflict message malformed");
  AST_ROOT: assert property (
    tok.tokValid && !endCmd && tok.tokDelim == `AICP_CH_COLON && atStart &&
      w == aicp_pkg::W_NONE |=> cmdSub == aicp_pkg::SUB_NONE)
    else $error("leading colon did not return to root");
  AST_LF_END: assert property (
    sLastLoad |=> sLfOut)
    else $error("reply not ended by line feed");
endmodule
`default_nettype wire

// ===== aicp_params.svh
// Character codes, sizes, reset values and reply text of the parser
`ifndef AICP_PARAMS_SVH
`define AICP_PARAMS_SVH
`define AICP_CH_LF 8'h0A
`define AICP_CH_CR 8'h0D
`define AICP_CH_SP 8'h20
`define AICP_CH_STAR 8'h2A
`define AICP_CH_MINUS 8'h2D
`define AICP_CH_ZERO 8'h30
`define AICP_CH_ONE 8'h31
`define AICP_CH_NINE 8'h39
`define AICP_CH_COLON 8'h3A
`define AICP_CH_SEMI 8'h3B
`define AICP_CH_QUERY 8'h3F
`define AICP_CH_UP_A 8'h41
`define AICP_CH_UP_Z 8'h5A
`define AICP_CH_LOW_A 8'h61
`define AICP_CH_LOW_Z 8'h7A
`define AICP_CASE_BIT 8'h20
`define AICP_WORD_MAX 4'h8
`define AICP_RST_OUTP 1'b0
`define AICP_RST_TRIG 1'b0
`define AICP_SUB_OUTP 1'b0
`define AICP_LRN_LEN 6'h19
`define AICP_LRN_SEMI_POS 6'h0B
`define AICP_ERR_LEN 6'h2A
`define AICP_NOERR_LEN 6'h02
`define AICP_OPC_LEN 6'h01
`define AICP_MSG_BITS 336
`define AICP_ERR_TEXT "-221,OUTP:STAT 1,TRIG:SOUR EXT;OUTP:STAT 0"
`define AICP_NOERR_TEXT "+0"
`endif

// ===== aicp_pkg.sv
// Types shared by the parser modules
`default_nettype none
package aicp_pkg;
  typedef enum logic [4:0] {
    W_NONE, W_UNK, W_RST, W_CLS, W_OPC, W_LRN, W_OUTP, W_STAT, W_TRIG,
    W_SOUR, W_SYST, W_ERR, W_ON, W_OFF, W_INT, W_EXT, W_ZERO, W_ONE
  } aicp_word_e;
  typedef enum logic [2:0] {
    SUB_NONE, SUB_OUTP, SUB_TRIG, SUB_SYST, SUB_BAD
  } aicp_sub_e;
  typedef enum logic [1:0] {SEG_LRN, SEG_ERR, SEG_OPC} aicp_seg_e;
  typedef enum logic {ST_PARSE, ST_EMIT} aicp_state_e;
endpackage
`default_nettype wire

// ===== aicp_tok_if.sv
// Token path from the lexer to the command parser
`timescale 1ns/1ps
`default_nettype none
interface aicp_tok_if;
  logic tokValid;
  aicp_pkg::aicp_word_e tokWord;
  logic [7:0] tokDelim;
  logic tokEol;
  logic resume;
  modport lex (output tokValid, tokWord, tokDelim, tokEol, input resume);
  modport prs (input tokValid, tokWord, tokDelim, tokEol, output resume);
endinterface
`default_nettype wire

// ===== aicp_lexer.sv
// Byte intake: folds case, gathers words, ends lines, drops returns that come without EOI
`timescale 1ns/1ps
`default_nettype none
`include "aicp_params.svh"
module aicp_lexer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host byte stream
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxEoi,
  output logic rxReady,
  // Tokens
  aicp_tok_if.lex tok
);
  logic take, isLow, isWord, isCr, isTerm, isDrop, overflow, emitOvf;
  logic [7:0] upCh;
  logic [63:0] wordBuf, bufIn, emitBuf;
  logic [3:0] wordLen;

  function automatic aicp_pkg::aicp_word_e wordOf(input logic [63:0] w,
                                                  input logic ovf);
    if (ovf) begin
      wordOf = aicp_pkg::W_UNK;
    end else begin
      case (w)
        64'h0000_0000_0000_0000: wordOf = aicp_pkg::W_NONE;
        64'("RST"): wordOf = aicp_pkg::W_RST;
        64'("CLS"): wordOf = aicp_pkg::W_CLS;
        64'("OPC"): wordOf = aicp_pkg::W_OPC;
        64'("LRN"): wordOf = aicp_pkg::W_LRN;
        64'("OUTP"), 64'("OUTPUT"): wordOf = aicp_pkg::W_OUTP;
        64'("STAT"), 64'("STATE"): wordOf = aicp_pkg::W_STAT;
        64'("TRIG"), 64'("TRIGGER"): wordOf = aicp_pkg::W_TRIG;
        64'("SOUR"), 64'("SOURCE"): wordOf = aicp_pkg::W_SOUR;
        64'("SYST"), 64'("SYSTEM"): wordOf = aicp_pkg::W_SYST;
        64'("ERR"), 64'("ERROR"): wordOf = aicp_pkg::W_ERR;
        64'("ON"): wordOf = aicp_pkg::W_ON;
        64'("OFF"): wordOf = aicp_pkg::W_OFF;
        64'("INT"), 64'("INTERNAL"): wordOf = aicp_pkg::W_INT;
        64'("EXT"), 64'("EXTERNAL"): wordOf = aicp_pkg::W_EXT;
        64'("0"): wordOf = aicp_pkg::W_ZERO;
        64'("1"): wordOf = aicp_pkg::W_ONE;
        default: wordOf = aicp_pkg::W_UNK;
      endcase
    end
  endfunction

  // ==========================================================
  // Character classes
  assign take = rxValid && rxReady;
  assign isLow = rxData >= `AICP_CH_LOW_A && rxData <= `AICP_CH_LOW_Z;
  assign upCh = isLow ? (rxData & ~`AICP_CASE_BIT) : rxData;
  assign isWord = (upCh >= `AICP_CH_UP_A && upCh <= `AICP_CH_UP_Z) ||
                  (upCh >= `AICP_CH_ZERO && upCh <= `AICP_CH_NINE);
  assign isCr = rxData == `AICP_CH_CR;
  assign isTerm = rxData == `AICP_CH_LF || rxEoi;
  assign isDrop = isCr && !rxEoi;
  assign bufIn = {wordBuf[55:0], upCh};
  assign emitBuf = isWord ? bufIn : wordBuf;
  assign emitOvf = overflow || (isWord && wordLen == `AICP_WORD_MAX);

  // ==========================================================
  // Intake and token output
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxReady <= 1'b1;
      tok.tokValid <= 1'b0;
      tok.tokWord <= aicp_pkg::W_NONE;
      tok.tokDelim <= 8'h00;
      tok.tokEol <= 1'b0;
      wordBuf <= 64'h0000_0000_0000_0000;
      wordLen <= 4'h0;
      overflow <= 1'b0;
    end else begin
      tok.tokValid <= 1'b0;
      // Stall the host until the reply to this line has gone out
      if (take && isTerm) begin
        rxReady <= 1'b0;
      end else if (tok.resume) begin
        rxReady <= 1'b1;
      end
      if (take && isWord && !rxEoi) begin
        if (wordLen == `AICP_WORD_MAX) begin
          overflow <= 1'b1;
        end else begin
          wordBuf <= bufIn;
          wordLen <= 4'(wordLen + 4'h1);
        end
      end else if (take && !isDrop) begin
        tok.tokValid <= 1'b1;
        tok.tokWord <= wordOf(emitBuf, emitOvf);
        tok.tokDelim <= (isWord || isCr) ? `AICP_CH_LF : upCh;
        tok.tokEol <= isTerm;
        wordBuf <= 64'h0000_0000_0000_0000;
        wordLen <= 4'h0;
        overflow <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  AST_CR_DROP: assert property (
    take && isDrop |=> !tok.tokValid)
    else $error("carriage return produced a token");
  AST_EOL: assert property (
    take && isTerm |=> tok.tokValid && tok.tokEol && !rxReady)
    else $error("terminator did not end the line");
endmodule
`default_nettype wire

// ===== aicp_host_model.sv
// Host controller model: sends command lines and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module aicp_host_model (
  // Clock
  input wire logic clk_sys,
  // Command bytes to the parser
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxEoi,
  input wire logic rxReady,
  // Reply bytes from the parser
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  logic slow;
  logic [7:0] replyQ[$];
  int stallCnt;

  // ==========================================
  // Command side
  // ASCII byte stream
  task automatic send_text(input string s, input logic eoiLast,
                           output logic ok);
    int n;
    ok = 1'b1;
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < s.len(); i++) begin
      rxData = s[i];
      rxValid = 1'b1;
      rxEoi = eoiLast && (i == s.len() - 1);
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (rxReady !== 1'b1 && n < 400);
      if (n >= 400) begin
        ok = 1'b0;
      end
      #1;
    end
    // Released line shows the inverse so a stale byte is never reused
    rxValid = 1'b0;
    rxEoi = 1'b0;
    rxData = ~rxData;
  endtask

  // ==========================================
  // Reply side
  always @(posedge clk_sys) begin
    if (txValid === 1'b1 && txReady === 1'b1) begin
      replyQ.push_back(txData);
    end
  end

  // When slow, only one cycle in three accepts a reply byte
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    rxEoi = 1'b0;
    slow = 1'b0;
    txReady = 1'b1;
    stallCnt = 0;
    forever begin
      @(posedge clk_sys);
      #1;
      stallCnt++;
      txReady = !slow || (stallCnt % 3 == 0);
    end
  end
endmodule
`default_nettype wire

// ===== test_ascii_instrument_command_parser.sv
// Self-checking bench of the ASCII command interpreter
`timescale 1ns/1ps
`default_nettype none
module test_ascii_instrument_command_parser;
  logic clk_sys;
  logic resetn;
  logic txReady;
  logic [7:0] rxData;
  logic rxValid;
  logic rxEoi;
  logic rxReady;
  logic [7:0] txData;
  logic txValid;
  logic outpState;
  logic trigExt;
  logic conflictErr;
  logic cmdErr;
  int n_mismatch;
  int checks_done;

  aicp_cmd_parser i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .rxData(rxData),
    .rxValid(rxValid), .rxEoi(rxEoi), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .outpState(outpState), .trigExt(trigExt),
    .conflictErr(conflictErr), .cmdErr(cmdErr)
  );

  aicp_host_model u_host (
    .clk_sys(clk_sys), .rxData(rxData), .rxValid(rxValid),
    .rxEoi(rxEoi), .rxReady(rxReady), .txData(txData),
    .txValid(txValid), .txReady(txReady)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Reporting and comparison
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_bit(input string what, input logic exp,
                         input logic got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_str(input string what, input string exp,
                         input string got);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected \"%s\" seen \"%s\"", what, exp, got);
    end
  endtask

  // ==========================================
  // Host actions
  task automatic send(input string s, input logic eoiLast);
    logic ok;
    u_host.send_text(s, eoiLast, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] rxReady expected 1 seen stuck low");
      close_out();
    end
  endtask

  // Settings land two edges after the terminator; four leaves margin
  task automatic line(input string s);
    send(s, 1'b0);
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic get_reply(input string what, input string exp);
    string got;
    int n;
    n = 0;
    while ((u_host.replyQ.size() == 0 || u_host.replyQ[$] != 8'h0A)
           && n < 600) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 600) begin
      n_mismatch++;
      $display("[FAIL] %s expected line end seen none", what);
      close_out();
    end
    got = "";
    foreach (u_host.replyQ[i]) got = {got, string'(u_host.replyQ[i])};
    u_host.replyQ.delete();
    cmp_str(what, exp, got);
  endtask

  // ==========================================
  // Scenarios
  task automatic s_power_on();
    cmp_bit("outpState", 1'b0, outpState);
    cmp_bit("trigExt", 1'b0, trigExt);
    send("*LRN?;*OPC?\n", 1'b0);
    get_reply("lrn", "OUTP:STAT 0;TRIG:SOUR INT;1\n");
  endtask

  task automatic s_header_forms();
    line("OUTPUT:STATE ON\n");
    cmp_bit("outpState", 1'b1, outpState);
    line("outp:st\rat off\r\n");
    cmp_bit("outpState", 1'b0, outpState);
    cmp_bit("cmdErr", 1'b0, cmdErr);
  endtask

  task automatic s_coupled();
    send("OUTP:STAT ON;", 1'b0);
    repeat (6) @(posedge clk_sys);
    cmp_bit("outpState", 1'b0, outpState);
    line(":TRIG:SOUR EXT;:OUTP:STAT OFF\n");
    cmp_bit("trigExt", 1'b1, trigExt);
    cmp_bit("conflictErr", 1'b0, conflictErr);
  endtask

  task automatic s_conflict();
    u_host.slow = 1'b1;
    line("OUTP:STAT ON\n");
    cmp_bit("conflictErr", 1'b1, conflictErr);
    cmp_bit("outpState", 1'b0, outpState);
    send("SYST:ERR?\n", 1'b0);
    get_reply("err", "-221,OUTP:STAT 1,TRIG:SOUR EXT;OUTP:STAT 0\n");
    cmp_bit("conflictErr", 1'b0, conflictErr);
    send("syst:err?\n", 1'b0);
    get_reply("noerr", "+0\n");
    u_host.slow = 1'b0;
  endtask

  task automatic s_terminators();
    send("*OPC?", 1'b1);
    get_reply("opc eoi", "1\n");
    send("*OPC?\r", 1'b1);
    get_reply("opc cr eoi", "1\n");
    send("*OPC?\n", 1'b1);
    get_reply("opc lf eoi", "1\n");
  endtask

  task automatic s_levels();
    line("OUTP:STAT ON;STAT OFF\n");
    cmp_bit("cmdErr", 1'b0, cmdErr);
    cmp_bit("conflictErr", 1'b0, conflictErr);
    line("OUTP:STAT OFF;TRIG:SOUR INT\n");
    cmp_bit("cmdErr", 1'b1, cmdErr);
  endtask

  task automatic s_rst_cls();
    line("OUTP:STAT ON\n");
    cmp_bit("conflictErr", 1'b1, conflictErr);
    // wait for completion before going on
    send("*RST;*CLS;*OPC?\n", 1'b0);
    get_reply("opc", "1\n");
    cmp_bit("outpState", 1'b0, outpState);
    cmp_bit("trigExt", 1'b0, trigExt);
    cmp_bit("conflictErr", 1'b0, conflictErr);
    cmp_bit("cmdErr", 1'b0, cmdErr);
    send("*lrn?\n", 1'b0);
    get_reply("lrn", "OUTP:STAT 0;TRIG:SOUR INT\n");
  endtask

  task automatic s_long_forms();
    // EOI on the last digit ends both the word and the line
    send("TRIGGER:SOURCE INTERNAL;:OUTP:STAT 1", 1'b1);
    repeat (4) @(posedge clk_sys);
    cmp_bit("outpState", 1'b1, outpState);
    cmp_bit("trigExt", 1'b0, trigExt);
    // Replies come in fixed order whatever order they were asked in
    send("system:error?;*opc?;*lrn?\n", 1'b0);
    get_reply("order", "OUTP:STAT 1;TRIG:SOUR INT;+0;1\n");
    // A header longer than eight characters is unknown
    line("OUTPUTSTATE 0\n");
    cmp_bit("cmdErr", 1'b1, cmdErr);
    cmp_bit("outpState", 1'b1, outpState);
    // Mid-run hardware reset returns the power-on state
    @(posedge clk_sys);
    #1;
    resetn = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp_bit("outpState", 1'b0, outpState);
    cmp_bit("cmdErr", 1'b0, cmdErr);
    cmp_bit("rxReady", 1'b1, rxReady);
    resetn = 1'b1;
    send("*OPC?\n", 1'b0);
    get_reply("opc after reset", "1\n");
  endtask

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    resetn = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    s_power_on();
    s_header_forms();
    s_coupled();
    s_conflict();
    s_terminators();
    s_levels();
    s_rst_cls();
    s_long_forms();
    close_out();
  end
endmodule
`default_nettype wire
